// ===== vcd_top.sv
// Purpose: power modes, serial registers and drive control of the coil driver
// Assumes: scl_clk is the serial clock pin, also used as the link clock
// Notes: serial framing runs on sys_clk from synchronised pins
`timescale 1ns/1ps
module vcd_top #(
	parameter logic [6:0] DEV_ADDR = 7'h0C,
	parameter int SCL_LOW_CYC = vcd_pkg::SCL_LOW_CYC_DEF,
	parameter int VBAT_GOOD_CYC = vcd_pkg::VBAT_GOOD_CYC_DEF
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic scl_clk,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic undervoltage_lockout,
	output logic coil_source_out,
	output logic coil_source_oe,
	output logic coil_sink_in_oe,
	output logic coil_linear_en,
	output logic [9:0] coil_current_code,
	output logic [7:0] slew_setting,
	output vcd_pkg::vcd_pwr_t power_mode
);
	import vcd_pkg::*;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	// Pin synchronisers: {undervoltage, data, clock}
	logic [2:0] meta_q;
	logic [2:0] sync_q;
	logic scl_d_q;
	logic sda_d_q;
	logic [7:0] link_shift_q;

	vcd_pwr_t pwr_q;
	vcd_pwr_t pwr_d;
	vcd_i2c_t i2c_q;
	logic [3:0] bit_cnt_q;
	logic ack_pend_q;
	logic [7:0] ptr_q;
	logic [7:0] tx_q;
	logic sda_oe_q;
	logic sda_out_q;
	logic bus_busy_q;
	logic [16:0] low_cnt_q;
	logic [14:0] good_cnt_q;

	logic [7:0] sys_ctrl_q;
	logic [9:0] cur_code_q;
	logic [7:0] mode_q;
	logic [7:0] shp_q;
	logic [7:0] slew_q;

	logic [15:0] pwm_cnt_q;
	logic [15:0] per_q;
	logic [7:0] lfsr_q;
	logic src_out_q;
	logic src_oe_q;
	logic sink_oe_q;
	logic lin_en_q;
	logic [9:0] code_out_q;
	logic [7:0] slew_out_q;

	vcd_shp_if shp_bus();

	function automatic logic [7:0] rd_mux(input logic [7:0] a);
		case (a)
			REG_SYS_CTRL: rd_mux = sys_ctrl_q;
			REG_CUR_MSB: rd_mux = {6'h00, cur_code_q[9:8]};
			REG_CUR_LSB: rd_mux = cur_code_q[7:0];
			REG_MODE: rd_mux = mode_q;
			REG_SHP: rd_mux = shp_q;
			REG_SLEW: rd_mux = slew_q;
			default: rd_mux = 8'h00;
		endcase
	endfunction

	// Link side: data bit taken on the clock pin's rising edge
	always_ff @(posedge scl_clk) begin
		link_shift_q <= {link_shift_q[6:0], sda_in};
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			meta_q <= 3'h0;
			sync_q <= 3'h0;
			scl_d_q <= 1'b0;
			sda_d_q <= 1'b0;
		end else begin
			meta_q <= {undervoltage_lockout, sda_in, scl_clk};
			sync_q <= meta_q;
			scl_d_q <= sync_q[0];
			sda_d_q <= sync_q[1];
		end
	end

	wire scl_s = sync_q[0];
	wire sda_s = sync_q[1];
	wire undervoltage_lockout_s = sync_q[2];
	wire scl_rise = scl_s & ~scl_d_q;
	wire scl_fall = ~scl_s & scl_d_q;
	wire i2c_start = scl_s & scl_d_q & sda_d_q & ~sda_s;
	wire i2c_stop = scl_s & scl_d_q & ~sda_d_q & sda_s;
	wire i2c_ok = (pwr_q != PWR_SHDN) & ~undervoltage_lockout_s;

	// Shift register is read only after the synchronised edge, when it has settled
	wire [7:0] rx_byte = link_shift_q;
	wire bit_ack = bit_cnt_q == 4'h8;
	wire byte_done = scl_rise && (bit_cnt_q == 4'h7);
	wire addr_hit = rx_byte[7:1] == DEV_ADDR;
	wire wr_en = byte_done && (i2c_q == I2_WR);
	wire wr_sys = wr_en && (ptr_q == REG_SYS_CTRL);
	wire wr_msb = wr_en && (ptr_q == REG_CUR_MSB);
	wire wr_lsb = wr_en && (ptr_q == REG_CUR_LSB);
	wire wr_mode = wr_en && (ptr_q == REG_MODE);
	wire wr_shp = wr_en && (ptr_q == REG_SHP);
	wire wr_slew = wr_en && (ptr_q == REG_SLEW);
	wire sw_reset = wr_sys && rx_byte[SYS_SW_RES_BIT];
	wire tx_bit = tx_q[3'(4'h7 - bit_cnt_q)];

	// Serial byte engine
	always_ff @(posedge sys_clk) begin
		if (!nrst || !i2c_ok || i2c_stop || i2c_start) begin
			i2c_q <= (nrst && i2c_ok && i2c_start) ? I2_ADDR : I2_IDLE;
			bit_cnt_q <= 4'h0;
			ack_pend_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else begin
			if (scl_rise) begin
				bit_cnt_q <= bit_ack ? 4'h0 : bit_cnt_q + 4'h1;
			end
			if (scl_rise && bit_ack) begin
				ack_pend_q <= 1'b0;
			end
			// Master NACK ends a read burst
			if (scl_rise && bit_ack && (i2c_q == I2_RD) && !ack_pend_q && sda_s) begin
				i2c_q <= I2_SKIP;
			end
			if (byte_done) begin
				case (i2c_q)
					I2_ADDR: begin
						ack_pend_q <= addr_hit;
						i2c_q <= !addr_hit ? I2_SKIP : (rx_byte[0] ? I2_RD : I2_PTR);
					end
					I2_PTR: begin
						ack_pend_q <= 1'b1;
						i2c_q <= I2_WR;
					end
					I2_WR: begin
						ack_pend_q <= 1'b1;
					end
					default: begin
					end
				endcase
			end
			if (scl_fall) begin
				sda_oe_q <= bit_ack ? ack_pend_q : ((i2c_q == I2_RD) & ~tx_bit);
			end
		end
	end

	// Pointer and read data, auto-increment per byte
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ptr_q <= 8'h00;
			tx_q <= 8'h00;
		end else if (byte_done && (i2c_q == I2_ADDR)) begin
			tx_q <= rd_mux(ptr_q);
		end else if (byte_done && (i2c_q == I2_PTR)) begin
			ptr_q <= rx_byte;
		end else if (wr_en) begin
			ptr_q <= ptr_q + 8'h01;
		end else if (scl_rise && bit_ack && (i2c_q == I2_RD) && !ack_pend_q) begin
			ptr_q <= ptr_q + 8'h01;
			tx_q <= rd_mux(ptr_q + 8'h01);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst || i2c_stop) begin
			bus_busy_q <= 1'b0;
		end else if (i2c_start && i2c_ok) begin
			bus_busy_q <= 1'b1;
		end
	end

	wire reg_clr = (pwr_q == PWR_SHDN) | undervoltage_lockout_s | sw_reset;

	always_ff @(posedge sys_clk) begin
		if (!nrst || reg_clr) begin
			sys_ctrl_q <= RST_REG;
			cur_code_q <= RST_CODE;
			mode_q <= RST_REG;
			shp_q <= RST_REG;
			slew_q <= RST_REG;
		end else begin
			if (wr_sys) begin
				sys_ctrl_q <= rx_byte;
			end
			if (wr_msb) begin
				cur_code_q[9:8] <= rx_byte[1:0];
			end
			if (wr_lsb) begin
				cur_code_q[7:0] <= rx_byte;
			end
			if (wr_mode) begin
				mode_q <= rx_byte;
			end
			if (wr_shp) begin
				shp_q <= rx_byte;
			end
			if (wr_slew) begin
				slew_q <= rx_byte;
			end
		end
	end

	wire low_done = low_cnt_q == 17'(SCL_LOW_CYC);
	always_ff @(posedge sys_clk) begin
		if (!nrst || scl_s || bus_busy_q || (pwr_q == PWR_SHDN)) begin
			low_cnt_q <= 17'h00000;
		end else if (!low_done) begin
			low_cnt_q <= low_cnt_q + 17'h00001;
		end
	end

	wire good_done = good_cnt_q == 15'(VBAT_GOOD_CYC);
	always_ff @(posedge sys_clk) begin
		if (!nrst || undervoltage_lockout_s) begin
			good_cnt_q <= 15'h0000;
		end else if (!good_done) begin
			good_cnt_q <= good_cnt_q + 15'h0001;
		end
	end

	wire code_nz = cur_code_q != 10'h000;

	always_comb begin
		pwr_d = pwr_q;
		case (pwr_q)
			PWR_SHDN: begin
				if (good_done && scl_s) begin
					pwr_d = PWR_STBY;
				end
			end
			PWR_STBY: begin
				if (low_done) begin
					pwr_d = PWR_SHDN;
				end else if (code_nz) begin
					pwr_d = PWR_ACT;
				end
			end
			PWR_ACT: begin
				if (low_done) begin
					pwr_d = PWR_SHDN;
				end else if (!code_nz) begin
					pwr_d = PWR_STBY;
				end
			end
			default: begin
				pwr_d = PWR_SHDN;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pwr_q <= PWR_SHDN;
		end else begin
			pwr_q <= pwr_d;
		end
	end

	assign shp_bus.target = cur_code_q;
	assign shp_bus.enable = sys_ctrl_q[SYS_SHP_EN_BIT];
	assign shp_bus.div_exp = shp_q[SHP_EXP_LSB +: 2];
	assign shp_bus.div_mult = shp_q[5:0];

	vcd_shaper u_shaper (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.sif(shp_bus)
	);

	wire [2:0] freq_sel = mode_q[MODE_FREQ_LSB +: 3];
	wire [15:0] per_nom = PWM_BASE_CYC + 16'(freq_sel) * PWM_STEP_CYC;
	wire [15:0] ss_span = 16'((32'(per_nom) * 32'(SS_PCT)) / 32'(PCT_FULL));
	wire [15:0] ss_ofs = 16'((32'(ss_span) * 32'(lfsr_q) * 32'h2) >> 8);
	wire ss_en = mode_q[MODE_SS_BIT];
	wire [15:0] per_next = ss_en ? per_nom - ss_span + ss_ofs : per_nom;
	wire pwm_wrap = pwm_cnt_q >= per_q - 16'h0001;
	// Open-loop duty; the analog loop trims the remaining error
	wire [15:0] duty = 16'((32'(per_q) * 32'(shp_bus.shaped)) >> 10);
	wire lin_sel = mode_q[MODE_LIN_BIT];
	wire act = pwr_q == PWR_ACT;

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pwm_cnt_q <= 16'h0000;
			per_q <= PWM_BASE_CYC;
			lfsr_q <= RST_LFSR;
		end else if (pwm_wrap) begin
			pwm_cnt_q <= 16'h0000;
			per_q <= per_next;
			lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
		end else begin
			pwm_cnt_q <= pwm_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			src_out_q <= 1'b0;
			src_oe_q <= 1'b0;
			sink_oe_q <= 1'b0;
			lin_en_q <= 1'b0;
			code_out_q <= RST_CODE;
			slew_out_q <= RST_REG;
			sda_out_q <= 1'b0;
		end else begin
			src_out_q <= act && !lin_sel && (pwm_cnt_q < duty);
			src_oe_q <= act && !lin_sel;
			sink_oe_q <= act;
			lin_en_q <= act && lin_sel;
			code_out_q <= act ? shp_bus.shaped : RST_CODE;
			slew_out_q <= slew_q;
			sda_out_q <= 1'b0;
		end
	end

	assign sda_out = sda_out_q;
	assign sda_oe = sda_oe_q;
	assign coil_source_out = src_out_q;
	assign coil_source_oe = src_oe_q;
	assign coil_sink_in_oe = sink_oe_q;
	assign coil_linear_en = lin_en_q;
	assign coil_current_code = code_out_q;
	assign slew_setting = slew_out_q;
	assign power_mode = pwr_q;

	a_shdn_clear: assert property (
		pwr_q == PWR_SHDN |=> cur_code_q == RST_CODE && mode_q == RST_REG && sys_ctrl_q == RST_REG)
		else $error("registers not cleared in shutdown");

	a_wake_cond: assert property (
		pwr_q == PWR_SHDN ##1 pwr_q == PWR_STBY |-> $past(good_done) && $past(scl_s))
		else $error("left shutdown without timeout and clock high");

	a_code_active: assert property (
		pwr_q == PWR_STBY && code_nz && !low_done |=> pwr_q == PWR_ACT)
		else $error("non-zero code did not start drive");

	a_low_shdn: assert property (
		pwr_q != PWR_SHDN && low_done |=> pwr_q == PWR_SHDN)
		else $error("long clock low did not shut down");

	a_low_min: assert property (
		pwr_q != PWR_SHDN ##1 pwr_q == PWR_SHDN |-> $past(low_cnt_q) == 17'(SCL_LOW_CYC))
		else $error("shutdown before clock-low time elapsed");

	a_timer_restart: assert property (
		scl_s |=> low_cnt_q == 17'h00000)
		else $error("clock-low timer not restarted");

	a_start_block: assert property (
		bus_busy_q && pwr_q != PWR_SHDN |=> pwr_q != PWR_SHDN)
		else $error("shutdown inside a serial frame");

	a_shdn_float: assert property (
		(pwr_q == PWR_SHDN) [*2] |-> !coil_source_oe && !coil_sink_in_oe && !sda_oe)
		else $error("pins driven in shutdown");

	a_stby_float: assert property (
		(pwr_q == PWR_STBY) [*2] |-> !coil_source_oe && !coil_sink_in_oe && !coil_linear_en)
		else $error("coil driven in standby");

	a_act_drive: assert property (
		(pwr_q == PWR_ACT) [*2] |-> coil_sink_in_oe && coil_linear_en == $past(lin_sel)
			&& coil_source_oe != coil_linear_en)
		else $error("active drive style wrong");

	a_ss_bound: assert property (
		pwm_wrap |=> per_q >= $past(per_nom - ss_span) && per_q <= $past(per_nom + ss_span))
		else $error("spread period outside 20 percent");

	a_undervoltage_lockout_clear: assert property (
		undervoltage_lockout_s |=> cur_code_q == RST_CODE && i2c_q == I2_IDLE)
		else $error("undervoltage did not clear and idle");
endmodule

// ===== vcd_pkg.sv
// Purpose: shared constants and types for the coil driver control block
// Assumes: system clock of 125 MHz (8 ns period)
// Notes: timeout and tick counts derive from the times below; PWM counts are given in cycles
package vcd_pkg;
	localparam int SYS_CLK_NS = 8;
	// Clock-low shutdown is a least time: round up
	localparam int SCL_LOW_MIN_NS = 740000;
	localparam int SCL_LOW_CYC_DEF = (SCL_LOW_MIN_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	// Supply-good timeout is a longest time: round down
	localparam int VBAT_GOOD_MAX_NS = 150000;
	localparam int VBAT_GOOD_CYC_DEF = VBAT_GOOD_MAX_NS / SYS_CLK_NS;
	// Internal shaper tick, typical figure
	localparam int TICK_NS = 1500;
	localparam logic [7:0] TICK_CYC = 8'(TICK_NS / SYS_CLK_NS);
	localparam int SHP_ALPHA_SHIFT = 3;

	localparam logic [7:0] REG_SYS_CTRL = 8'h02;
	localparam logic [7:0] REG_CUR_MSB = 8'h03;
	localparam logic [7:0] REG_CUR_LSB = 8'h04;
	localparam logic [7:0] REG_MODE = 8'h06;
	localparam logic [7:0] REG_SHP = 8'h07;
	localparam logic [7:0] REG_SLEW = 8'h08;

	localparam int SYS_SW_RES_BIT = 0;
	localparam int SYS_SHP_EN_BIT = 1;
	localparam int MODE_LIN_BIT = 1;
	localparam int MODE_FREQ_LSB = 2;
	localparam int MODE_SS_BIT = 6;
	localparam int SHP_EXP_LSB = 6;

	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [9:0] RST_CODE = 10'h000;
	localparam logic [7:0] RST_LFSR = 8'h01;

	localparam logic [15:0] PWM_BASE_CYC = 16'h0032;
	localparam logic [15:0] PWM_STEP_CYC = 16'h000A;
	localparam logic [15:0] SS_PCT = 16'h0014;
	localparam logic [15:0] PCT_FULL = 16'h0064;

	typedef enum logic [1:0] {
		PWR_SHDN = 2'b00,
		PWR_STBY = 2'b01,
		PWR_ACT = 2'b10
	} vcd_pwr_t;

	typedef enum logic [2:0] {
		I2_IDLE = 3'b000,
		I2_ADDR = 3'b001,
		I2_PTR = 3'b010,
		I2_WR = 3'b011,
		I2_RD = 3'b100,
		I2_SKIP = 3'b101
	} vcd_i2c_t;
endpackage

// ===== vcd_shp_if.sv
// Purpose: carries the shaper setup and its shaped current code
// Assumes: both ends on sys_clk
// Notes: control end drives setup, shaper end returns the code
`timescale 1ns/1ps
interface vcd_shp_if;
	logic [9:0] target;
	logic enable;
	logic [1:0] div_exp;
	logic [5:0] div_mult;
	logic [9:0] shaped;
	modport ctl (output target, output enable, output div_exp, output div_mult, input shaped);
	modport shp (input target, input enable, input div_exp, input div_mult, output shaped);
endinterface

// ===== vcd_shaper.sv
// Purpose: digital transition shaper, first-order low-pass on code steps
// Assumes: setup fields change rarely
// Notes: update every 4 * 2^exp * mult ticks, gain 1/8 per update
`timescale 1ns/1ps
module vcd_shaper (
	input wire logic sys_clk,
	input wire logic nrst,
	vcd_shp_if.shp sif
);
	import vcd_pkg::*;

	logic [7:0] tick_cnt_q;
	logic [10:0] step_cnt_q;
	logic [15:0] acc_q;

	// Zero multiplier would stall the filter; treat as one
	wire [10:0] mult_eff = {5'h00, (sif.div_mult == 6'h00) ? 6'h01 : sif.div_mult};
	wire [10:0] step_len = mult_eff << (3'(sif.div_exp) + 3'h2);
	wire tick = tick_cnt_q == TICK_CYC - 8'h01;
	wire step = tick && (step_cnt_q >= step_len - 11'h001);
	wire signed [16:0] diff = $signed({1'b0, sif.target, 6'h00}) - $signed({1'b0, acc_q});
	// Snap the last fraction so the output lands on the target exactly
	wire snap = (diff < 17'sh00008) && (diff > -17'sh00008);
	wire [15:0] acc_step = acc_q + 16'(diff >>> SHP_ALPHA_SHIFT);

	always_ff @(posedge sys_clk) begin
		if (!nrst || tick) begin
			tick_cnt_q <= 8'h00;
		end else begin
			tick_cnt_q <= tick_cnt_q + 8'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst || step) begin
			step_cnt_q <= 11'h000;
		end else if (tick) begin
			step_cnt_q <= step_cnt_q + 11'h001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			acc_q <= 16'h0000;
		end else if (!sif.enable) begin
			acc_q <= {sif.target, 6'h00};
		end else if (step) begin
			acc_q <= snap ? {sif.target, 6'h00} : acc_step;
		end
	end

	assign sif.shaped = acc_q[15:6];

	a_shp_bypass: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		!sif.enable |=> sif.shaped == $past(sif.target))
		else $error("shaper bypass does not pass the code");
endmodule

// ===== vcd_host_model.sv
// Purpose: behavioural I2C host on the serial pins of the coil driver
// Assumes: open-drain data line, pull-up resolved in the bench
// Notes: clock stands high between frames, 80 ns bit period
`timescale 1ns/1ps
module vcd_host_model #(
	parameter logic [6:0] ADDR = 7'h0C
) (
	output logic scl_clk,
	output logic sda_pull,
	input wire logic sda_w
);
	initial begin
		scl_clk = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic set_scl(input logic v);
		scl_clk = v;
	endtask
	// Data changes only while clock low
	task automatic bit_io(input logic b, output logic r);
		sda_pull = !b;
		#20 scl_clk = 1'b1;
		#20 r = sda_w;
		#20 scl_clk = 1'b0;
		#20;
	endtask
	// Clock stands high a while before data falls, else the START is missed
	task automatic start;
		if (!scl_clk) begin
			sda_pull = 1'b0;
			#20 scl_clk = 1'b1;
		end
		#20 sda_pull = 1'b1;
		#20 scl_clk = 1'b0;
		#20;
	endtask
	task automatic stop;
		sda_pull = 1'b1;
		#20 scl_clk = 1'b1;
		#20 sda_pull = 1'b0;
		#40;
	endtask
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(last, r);
		ack = !r;
	endtask
	task automatic write_reg(input logic [7:0] p, input logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic a1, a2, a3;
		start();
		xfer({ADDR, 1'b0}, 1'b1, q, a1);
		xfer(p, 1'b1, q, a2);
		xfer(d, 1'b1, q, a3);
		stop();
		ok = a1 & a2 & a3;
	endtask
	// Single byte read ends in NACK
	task automatic read_reg(input logic [7:0] p, output logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic a1, a2, a3, a4;
		start();
		xfer({ADDR, 1'b0}, 1'b1, q, a1);
		xfer(p, 1'b1, q, a2);
		start();
		xfer({ADDR, 1'b1}, 1'b1, q, a3);
		xfer(8'hFF, 1'b1, d, a4);
		stop();
		ok = a1 & a2 & a3;
	endtask
endmodule

// ===== test_coil_driver_mode_and_shaper_control.sv
// Purpose: self-checking bench for the coil driver control block
// Assumes: shortened clock-low and supply-good counts
// Notes: serial traffic comes from the host model
`timescale 1ns/1ps
module test_coil_driver_mode_and_shaper_control;
	import vcd_pkg::*;
	localparam int SCL_LOW = 200;
	localparam int VBAT = 50;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic undervoltage_lockout = 1'b0;
	wire logic scl_clk;
	wire logic sda_pull;
	wire logic sda_w;
	logic sda_out, sda_oe, src, src_oe, sink_oe, lin_en;
	logic [9:0] code;
	logic [7:0] slew;
	vcd_pwr_t mode;
	int err_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	// Pull-up wins unless someone pulls low
	assign sda_w = !(sda_pull || (sda_oe && !sda_out));
	always #4 sys_clk = ~sys_clk;
	vcd_top #(.SCL_LOW_CYC(SCL_LOW), .VBAT_GOOD_CYC(VBAT)) dut (.sys_clk(sys_clk),
		.nrst(nrst), .scl_clk(scl_clk), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
		.undervoltage_lockout(undervoltage_lockout), .coil_source_out(src),
		.coil_source_oe(src_oe), .coil_sink_in_oe(sink_oe), .coil_linear_en(lin_en),
		.coil_current_code(code), .slew_setting(slew), .power_mode(mode));
	vcd_host_model host (.scl_clk(scl_clk), .sda_pull(sda_pull), .sda_w(sda_w));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("mismatches %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic cycles(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic ok;
		host.write_reg(p, d, ok);
		check(ok, 1'b1);
		cycles(2);
	endtask
	task automatic rd(input logic [7:0] p, input logic [7:0] e);
		logic ok;
		logic [7:0] d;
		host.read_reg(p, d, ok);
		check(ok, 1'b1);
		check(d, e);
	endtask
	task automatic wait_mode(input vcd_pwr_t m, input int lim, output int n);
		n = 0;
		while (mode !== m && n < lim) begin
			cycles(1);
			n++;
		end
	endtask
	task automatic wait_lvl(input logic v, output int k);
		k = 0;
		while (src !== v && k < 400) begin
			cycles(1);
			k++;
		end
	endtask
	task automatic period(output int p, output int h);
		int a, b;
		wait_lvl(1'b0, a);
		wait_lvl(1'b1, a);
		wait_lvl(1'b0, h);
		wait_lvl(1'b1, b);
		p = h + b;
	endtask
	task automatic go_active(input logic [7:0] m);
		int n;
		wr(REG_CUR_LSB, 8'h00);
		check(mode, PWR_STBY);
		check({src_oe, sink_oe, lin_en}, 3'b000);
		wr(REG_MODE, m);
		wr(REG_CUR_LSB, 8'h80);
		wait_mode(PWR_ACT, 5, n);
		check(n < 5, 1'b1);
	endtask
	task automatic t_power_up;
		int n;
		check(mode, PWR_SHDN);
		check({src_oe, sink_oe, sda_oe, code}, 13'h0000);
		wait_mode(PWR_STBY, 200, n);
		check(n >= VBAT - 2 && n <= VBAT + 6, 1'b1);
		wr(REG_SLEW, 8'h0B);
		check(slew, 8'h0B);
		rd(REG_SLEW, 8'h0B);
		rd(8'h0A, 8'h00);
	endtask
	task automatic t_pwm;
		int p, h, lo, hi;
		for (int f = 0; f < 8; f++) begin
			go_active(8'(f << MODE_FREQ_LSB));
			check({sink_oe, src_oe, lin_en}, 3'b110);
			period(p, h);
			check(p, 50 + 10 * f);
			check(h >= (p * 128) / 1024 && h <= (p * 128) / 1024 + 1, 1'b1);
		end
		go_active(8'h40);
		lo = 999;
		hi = 0;
		repeat (8) begin
			period(p, h);
			lo = (p < lo) ? p : lo;
			hi = (p > hi) ? p : hi;
		end
		check(lo >= 40 && hi <= 60 && lo != hi, 1'b1);
		go_active(8'h02);
		check({sink_oe, src_oe, lin_en, src}, 4'b1010);
	endtask
	task automatic t_shaper;
		int n;
		check(code, 10'h080);
		// High cutoff: exponent 0, multiplier 1
		wr(REG_SHP, 8'h01);
		wr(REG_SYS_CTRL, 8'h02);
		wr(REG_CUR_MSB, 8'h03);
		check(code, 10'h080);
		n = 0;
		while (code === 10'h080 && n < 800) begin
			cycles(1);
			n++;
		end
		check(code, 10'h0E0);
		n = 0;
		while (code === 10'h0E0 && n < 800) begin
			cycles(1);
			n++;
		end
		check(n, 4 * 187);
		check(code, 10'h134);
	endtask
	task automatic t_clock_low;
		int n;
		host.set_scl(1'b0);
		cycles(SCL_LOW - 50);
		host.set_scl(1'b1);
		cycles(5);
		host.set_scl(1'b0);
		cycles(SCL_LOW - 50);
		check(mode, PWR_ACT);
		host.set_scl(1'b1);
		host.start();
		cycles(SCL_LOW + 100);
		check(mode, PWR_ACT);
		host.stop();
		host.set_scl(1'b0);
		cycles(SCL_LOW - 10);
		check(mode, PWR_ACT);
		cycles(20);
		check(mode, PWR_SHDN);
		check({src_oe, sink_oe, sda_oe, lin_en, slew}, 12'h000);
		host.set_scl(1'b1);
		wait_mode(PWR_STBY, VBAT + 20, n);
		// Supply-good timeout ran out long ago: wake follows the synced clock
		check(n >= 2 && n <= 4, 1'b1);
		rd(REG_SLEW, 8'h00);
		rd(REG_MODE, 8'h00);
	endtask
	task automatic t_undervoltage;
		logic ok;
		wr(REG_SLEW, 8'h07);
		undervoltage_lockout = 1'b1;
		cycles(5);
		check(slew, 8'h00);
		host.write_reg(REG_SLEW, 8'h09, ok);
		check({ok, slew}, 9'h000);
		undervoltage_lockout = 1'b0;
		cycles(5);
		wr(REG_SLEW, 8'h09);
		check(slew, 8'h09);
	endtask
	// Reset again in mid-run, from active drive
	task automatic t_reset;
		int n;
		wr(REG_CUR_LSB, 8'h40);
		check(mode, PWR_ACT);
		nrst = 1'b0;
		cycles(3);
		check(mode, PWR_SHDN);
		check({src_oe, sink_oe, lin_en, sda_oe, sda_out, slew}, 13'h0000);
		check(code, 10'h000);
		nrst = 1'b1;
		cycles(1);
		check(mode, PWR_SHDN);
		wait_mode(PWR_STBY, 200, n);
		check(n >= VBAT - 3 && n <= VBAT + 5, 1'b1);
		rd(REG_CUR_LSB, 8'h00);
	endtask
	initial begin
		cycles(10);
		nrst = 1'b1;
		t_power_up();
		t_pwm();
		t_shaper();
		t_clock_low();
		t_undervoltage();
		t_reset();
		report_and_stop();
	end
endmodule
